// *** design/ste_regs.svh ***
// register offsets, field positions and reset values of the timer engine
// assumes a 32-bit avalon slave with byte addresses, one word per register
`ifndef STE_REGS_SVH
`define STE_REGS_SVH

// byte addresses of the word registers
`define STE_ADDR_CTRL 5'h00
`define STE_ADDR_CMPA 5'h04
`define STE_ADDR_CMPP 5'h08
`define STE_ADDR_COUNT 5'h0C
`define STE_ADDR_STATUS 5'h10

// control word fields
`define STE_CTRL_CLRSEL 0
`define STE_CTRL_SWAP 1
`define STE_CTRL_INVERT 2
`define STE_CTRL_INIT 3
`define STE_CTRL_FUNC_LO 4
`define STE_CTRL_FUNC_HI 5
`define STE_CTRL_MODE_LO 6
`define STE_CTRL_MODE_HI 7
`define STE_CTRL_RUN 8
`define STE_CTRL_WIDTH 9

// status word fields
`define STE_STAT_AFLAG 0
`define STE_STAT_PFLAG 1
`define STE_STAT_PIN 2

// reset values
`define STE_CTRL_RESET 9'h000
`define STE_CMPA_RESET 16'h0000
`define STE_CMPP_RESET 8'h00

`endif

// *** design/ste_pkg.sv ***
// types shared by the timer engine modules
// assumes the field layout of ste_regs.svh
package ste_pkg;

  // operating mode, encoded as the two mode select bits
  typedef enum logic [1:0] {
    STE_MODE_COMPARE,
    STE_MODE_UNDEF,
    STE_MODE_PWM,
    STE_MODE_TIMER
  } ste_mode_t;

  // output function; meaning depends on the mode
  typedef enum logic [1:0] {
    STE_FUNC_HOLD,
    STE_FUNC_LOW,
    STE_FUNC_HIGH,
    STE_FUNC_TOGGLE
  } ste_func_t;

endpackage : ste_pkg

// *** design/ste_counter.sv ***
// 16-bit up-counter with comparator a (full width) and p (top byte)
// assumes run, restart and clear come from the same clock domain
`timescale 1ns/1ps
module ste_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic run,
  input wire logic restart,
  input wire logic clear,
  input wire logic [WIDTH-1:0] cmpA,
  input wire logic [7:0] cmpP,
  output logic [WIDTH-1:0] count,
  output logic aMatch,
  output logic pMatch
);

  logic [WIDTH-1:0] countInc;

  // matches are taken at the end of the cycle whose successor equals the
  // compare value, so a zero value matches on overflow
  assign countInc = count + {{(WIDTH-1){1'b0}}, 1'b1};
  assign aMatch = run & ~restart & (countInc == cmpA);
  // p sees only the top byte: matches fall on multiples of 256 [R23]
  assign pMatch = run & ~restart & (countInc[WIDTH-1:WIDTH-8] == cmpP)
    & (&count[WIDTH-9:0]);

  // count while running, zero after a clear or a run rising edge [R25]
  always_ff @(posedge clock) begin
    if (srst) begin
      count <= '0;
    end else if (restart) begin
      count <= '0;
    end else if (run) begin
      count <= clear ? '0 : countInc;
    end
  end

endmodule : ste_counter

// *** design/ste_pin.sv ***
// output pin driver for compare, pwm and single pulse modes
// assumes the strobes are one-cycle pulses on the same clock
`timescale 1ns/1ps
module ste_pin (
  input wire logic clock,
  input wire logic srst,
  input wire ste_pkg::ste_mode_t mode,
  input wire ste_pkg::ste_func_t func,
  input wire logic initLevel,
  input wire logic invert,
  input wire logic restart,
  input wire logic aMatch,
  input wire logic run,
  input wire logic pwmActive,
  output logic pin,
  output logic pinOe
);

  logic active;

  // pwm activity: forced, waveform or single pulse [R17]
  always_comb begin
    unique case (func)
      ste_pkg::STE_FUNC_HOLD: active = 1'b0;
      ste_pkg::STE_FUNC_LOW: active = 1'b1;
      ste_pkg::STE_FUNC_HIGH: active = pwmActive;
      ste_pkg::STE_FUNC_TOGGLE: active = run; // pulse spans run [R20] [R21]
    endcase
  end

  // pin level; timer mode releases the pin [R10]
  always_ff @(posedge clock) begin
    if (srst) begin
      pin <= 1'b0;
      pinOe <= 1'b0;
    end else begin
      unique case (mode)
        ste_pkg::STE_MODE_COMPARE: begin
          pinOe <= 1'b1;
          if (restart) begin
            pin <= initLevel; // [R09]
          end else if (aMatch) begin // only a matches move the pin [R06]
            unique case (func)
              ste_pkg::STE_FUNC_HOLD: pin <= pin; // [R08]
              ste_pkg::STE_FUNC_LOW: pin <= 1'b0; // [R07]
              ste_pkg::STE_FUNC_HIGH: pin <= 1'b1;
              ste_pkg::STE_FUNC_TOGGLE: pin <= ~pin;
            endcase
          end
        end
        ste_pkg::STE_MODE_PWM: begin
          pinOe <= 1'b1;
          // active level chosen by initLevel, then optional inversion
          pin <= (active ? initLevel : ~initLevel) ^ invert; // [R24] [R18]
        end
        ste_pkg::STE_MODE_UNDEF, ste_pkg::STE_MODE_TIMER: begin
          pinOe <= 1'b0;
        end
      endcase
    end
  end

endmodule : ste_pin

// *** design/ste_timer.sv ***
// standard timer mode engine with an avalon-mm register slave
// assumes one 100 MHz clock; the counter ticks on every rising clock edge
//
// Overview of operation
// R01 - mode zero selects compare-match output
// R02 - clear on p match or overflow
// R03 - compare mode raises both match flags
// R04 - clear-select high: clear on a, a flag only
// R05 - software keeps compare a nonzero there
// R06 - only a matches change the pin
// R07 - a match sets, clears or toggles pin
// R08 - function zero leaves pin unchanged
// R09 - run rising edge loads initial level
// R10 - timer mode like compare, pin released
// R11 - software picks mode 10, function 10
// R12 - pwm ignores clear-select; swap picks period
// R13 - swap zero: p period, a duty
// R14 - swap one: a period, p duty
// R15 - duty at least period: always active
// R16 - pwm raises a and p flags
// R17 - functions 00/01 force pin, counting continues
// R18 - invert bit flips pwm waveform
// R19 - software picks function 11, keeps it
// R20 - run rising edge starts pulse
// R21 - a match ends pulse, clears run
// R22 - single pulse restarts only on run
// R23 - p compares counter top byte only
// R24 - initial level bit picks active level
// R25 - counter increments by one while running
`timescale 1ns/1ps
`include "ste_regs.svh"
module ste_timer (
  input wire logic clock,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic timerPin,
  output logic timerPinOe
);

  // register state
  logic [`STE_CTRL_WIDTH-1:0] ctrl_r;
  logic [15:0] cmpA_r;
  logic [7:0] cmpP_r;
  logic aFlag_r;
  logic pFlag_r;
  logic runPrev_r;
  logic waitReq_r;
  logic [31:0] readData_r;

  // decoded control fields
  ste_pkg::ste_mode_t mode;
  ste_pkg::ste_func_t func;
  logic clrSel;
  logic swap;
  logic run;
  logic singlePulse;
  logic pwmMode;
  logic restart;

  // counter side
  logic [15:0] count;
  logic aMatch;
  logic pMatch;
  logic clear;
  logic aSet;
  logic pSet;
  logic pwmActive;
  logic [16:0] pPeriod;
  logic [16:0] aPeriod;
  logic [16:0] duty;
  logic [16:0] period;

  // bus side
  logic wrTake;
  logic [31:0] wordMerged;
  logic [31:0] readMux;
  logic runHwClear;
  logic statClr;

  // merge write data into a word under the byte enables
  function automatic logic [31:0] byteMerge(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = newVal[8*i +: 8];
      end
    end
    return res;
  endfunction : byteMerge

  // a zero period or p duty stands for the full 65536-count range; the
  // result is 17 bits wide so that this full count stays representable
  function automatic logic [16:0] fullScale(
    input logic [15:0] val
  );
    return (val == 16'h0000) ? 17'h10000 : {1'b0, val};
  endfunction : fullScale

  // true on the edge that completes a write to the given word; the
  // write strobe alone is not enough, it stands through the wait state
  function automatic logic wrHit(
    input logic take,
    input logic [4:0] addr,
    input logic [4:0] target
  );
    return take && (addr == target);
  endfunction : wrHit

  // field decode; the control word has nine bits, the rest read zero
  assign mode = ste_pkg::ste_mode_t'(
    ctrl_r[`STE_CTRL_MODE_HI:`STE_CTRL_MODE_LO]); // [R01] [R10]
  assign func = ste_pkg::ste_func_t'(
    ctrl_r[`STE_CTRL_FUNC_HI:`STE_CTRL_FUNC_LO]);
  assign clrSel = ctrl_r[`STE_CTRL_CLRSEL];
  assign swap = ctrl_r[`STE_CTRL_SWAP];
  assign run = ctrl_r[`STE_CTRL_RUN];

  // mode 10 with function 11 is the single pulse mode; software is
  // expected not to touch the function field while in it
  assign pwmMode = (mode == ste_pkg::STE_MODE_PWM);
  assign singlePulse = pwmMode
    & (func == ste_pkg::STE_FUNC_TOGGLE); // [R19] [R11]

  // run rising edge restarts the counter and the output; the edge is
  // seen one cycle after the write, which software cannot observe
  assign restart = run & ~runPrev_r; // [R09] [R20] [R22]

  // counter clear source per mode
  always_comb begin
    clear = 1'b0;
    unique case (mode)
      ste_pkg::STE_MODE_PWM: begin
        if (singlePulse) begin
          clear = 1'b0; // only a run rising edge zeroes it [R22]
        end else if (swap) begin
          clear = aMatch; // a sets the period [R14] [R12]
        end else begin
          clear = pMatch; // p sets the period [R13]
        end
      end
      ste_pkg::STE_MODE_COMPARE, ste_pkg::STE_MODE_UNDEF,
      ste_pkg::STE_MODE_TIMER: begin
        // p match covers overflow when p is zero [R02] [R04]
        clear = clrSel ? aMatch : pMatch;
      end
    endcase
  end

  // flag set terms per mode
  always_comb begin
    aSet = aMatch; // a flag in every mode [R03] [R16] [R21]
    pSet = 1'b0;
    unique case (mode)
      ste_pkg::STE_MODE_PWM: begin
        pSet = pMatch & ~singlePulse; // [R16]
      end
      ste_pkg::STE_MODE_COMPARE, ste_pkg::STE_MODE_UNDEF,
      ste_pkg::STE_MODE_TIMER: begin
        pSet = pMatch & ~clrSel; // no p flag when a clears [R04] [R03]
      end
    endcase
  end

  // p counts in steps of 256 clocks, a in single clocks
  assign pPeriod = fullScale({cmpP_r, 8'h00}); // [R13] [R23]
  assign aPeriod = fullScale(cmpA_r); // [R14]

  // swap selects which register gives period and which gives duty
  always_comb begin
    if (swap) begin
      period = aPeriod; // [R14]
      duty = pPeriod;
    end else begin
      period = pPeriod; // [R13]
      duty = {1'b0, cmpA_r};
    end
  end

  // duty at or past the period keeps the output active [R15]; the
  // compare is 17 bits wide so a full-range duty still beats any
  // shorter period
  assign pwmActive = ({1'b0, count} < duty) | (duty >= period);

  // counter and comparators
  ste_counter #(
    .WIDTH(16)
  ) u_counter (
    .clock(clock),
    .srst(srst),
    .run(run),
    .restart(restart),
    .clear(clear),
    .cmpA(cmpA_r),
    .cmpP(cmpP_r),
    .count(count),
    .aMatch(aMatch),
    .pMatch(pMatch)
  );

  // output pin logic
  ste_pin u_pin (
    .clock(clock),
    .srst(srst),
    .mode(mode),
    .func(func),
    .initLevel(ctrl_r[`STE_CTRL_INIT]),
    .invert(ctrl_r[`STE_CTRL_INVERT]),
    .restart(restart),
    .aMatch(aMatch),
    .run(run),
    .pwmActive(pwmActive),
    .pin(timerPin),
    .pinOe(timerPinOe)
  );

  // a write takes effect on the edge where waitrequest is seen low
  assign wrTake = avs_write & ~waitReq_r;

  // byte-enable merge of the addressed word's current contents
  assign wordMerged = byteMerge(readMux, avs_writedata, avs_byteenable);

  // hardware end of a single pulse; the counter stops by itself
  // because run drops at the match edge
  assign runHwClear = singlePulse & aMatch; // [R21]

  // write-one-to-clear of the flags needs byte lane zero
  assign statClr = wrHit(wrTake, avs_address, `STE_ADDR_STATUS)
    & avs_byteenable[0];

  // control word; a software write in the same cycle wins over the
  // hardware run clear, so a deliberate restart is never lost
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_r <= `STE_CTRL_RESET;
    end else if (wrHit(wrTake, avs_address, `STE_ADDR_CTRL)) begin
      ctrl_r <= wordMerged[`STE_CTRL_WIDTH-1:0];
    end else if (runHwClear) begin
      ctrl_r[`STE_CTRL_RUN] <= 1'b0; // [R21]
    end
  end

  // compare a; zero in compare mode is left to software [R05]
  always_ff @(posedge clock) begin
    if (srst) begin
      cmpA_r <= `STE_CMPA_RESET;
    end else if (wrHit(wrTake, avs_address, `STE_ADDR_CMPA)) begin
      cmpA_r <= wordMerged[15:0];
    end
  end

  // compare p; only the low byte of the word is kept
  always_ff @(posedge clock) begin
    if (srst) begin
      cmpP_r <= `STE_CMPP_RESET;
    end else if (wrHit(wrTake, avs_address, `STE_ADDR_CMPP)) begin
      cmpP_r <= wordMerged[7:0];
    end
  end

  // previous run level for edge detection
  always_ff @(posedge clock) begin
    if (srst) begin
      runPrev_r <= 1'b0;
    end else begin
      runPrev_r <= run;
    end
  end

  // sticky a flag, write one to clear; a set in the clearing cycle
  // wins so no match is lost
  always_ff @(posedge clock) begin
    if (srst) begin
      aFlag_r <= 1'b0;
    end else if (statClr) begin
      aFlag_r <= aSet | (aFlag_r & ~avs_writedata[`STE_STAT_AFLAG]);
    end else begin
      aFlag_r <= aSet | aFlag_r; // [R03] [R16] [R21]
    end
  end

  // sticky p flag, same clearing rule as the a flag
  always_ff @(posedge clock) begin
    if (srst) begin
      pFlag_r <= 1'b0;
    end else if (statClr) begin
      pFlag_r <= pSet | (pFlag_r & ~avs_writedata[`STE_STAT_PFLAG]);
    end else begin
      pFlag_r <= pSet | pFlag_r; // [R03] [R16]
    end
  end

  // read multiplexer; unmapped words and reserved bits read zero
  always_comb begin
    readMux = 32'h00000000;
    unique case (avs_address)
      `STE_ADDR_CTRL: readMux[`STE_CTRL_WIDTH-1:0] = ctrl_r;
      `STE_ADDR_CMPA: readMux[15:0] = cmpA_r;
      `STE_ADDR_CMPP: readMux[7:0] = cmpP_r;
      `STE_ADDR_COUNT: readMux[15:0] = count;
      `STE_ADDR_STATUS: begin
        readMux[`STE_STAT_AFLAG] = aFlag_r;
        readMux[`STE_STAT_PFLAG] = pFlag_r;
        readMux[`STE_STAT_PIN] = timerPin;
      end
      default: readMux = 32'h00000000;
    endcase
  end

  // one wait state per access: waitrequest drops for exactly one cycle
  // after a request is seen, which keeps read data registered
  always_ff @(posedge clock) begin
    if (srst) begin
      waitReq_r <= 1'b1;
    end else if (!waitReq_r) begin
      waitReq_r <= 1'b1;
    end else if (avs_read || avs_write) begin
      waitReq_r <= 1'b0;
    end
  end

  // read data captured while the wait state ends; registering it costs
  // the wait state but keeps the read path short
  always_ff @(posedge clock) begin
    if (srst) begin
      readData_r <= 32'h00000000;
    end else if (avs_read && waitReq_r) begin
      readData_r <= readMux;
    end
  end

  assign avs_waitrequest = waitReq_r;
  assign avs_readdata = readData_r;

endmodule : ste_timer

// *** tb/ste_timer_asserts.sv ***
// checker for the timer engine, bound to ste_timer
// assumes only the top ports; shadows the control byte from bus writes
`timescale 1ns/1ps
module ste_timer_asserts (
  input wire logic clock,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic timerPin,
  input wire logic timerPinOe
);
  logic [7:0] ctrlR;
  logic [7:0] ctrlQ;
  logic runR;
  logic runQ;
  logic ctrlWr;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // a control write lands at the edge waitrequest is low
  assign ctrlWr = avs_write && !avs_waitrequest && avs_address == 5'h00;
  // shadow; run trusted in compare mode only, hw clears it in single pulse mode
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrlR <= 8'h00;
      runR <= 1'b0;
    end else if (ctrlWr) begin
      if (avs_byteenable[0]) ctrlR <= avs_writedata[7:0];
      if (avs_byteenable[1]) runR <= avs_writedata[8];
    end
  end
  // delayed copy; odd reset value marks control as just changed
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrlQ <= 8'hFF;
      runQ <= 1'b0;
    end else begin
      ctrlQ <= ctrlR;
      runQ <= runR;
    end
  end
  sequence s_accept;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_run_rise;
    ctrlR[7:6] == 2'b00 && runR && !runQ;
  endsequence
  a_wait_answer: assert property (s_accept |=> !avs_waitrequest)
    else $error("no answer after accept");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_idle: assert property (
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  a_read_unmapped: assert property (
    s_accept ##0 avs_read && avs_address >= 5'h14 |=> avs_readdata == 0)
    else $error("unmapped read not zero");
  a_oe_mode: assert property (
    ctrlR == ctrlQ |-> timerPinOe == !ctrlR[6])
    else $error("pin enable wrong for mode");
  a_run_init: assert property (s_run_rise |=> timerPin == ctrlR[3])
    else $error("initial level not loaded");
  a_hold_pin: assert property (
    ctrlR == ctrlQ && ctrlR[7:4] == 4'h0 && !(runR && !runQ)
    |=> $stable(timerPin))
    else $error("pin moved with function zero");
  a_pin_forced: assert property (
    ctrlR == ctrlQ && ctrlR[7:5] == 3'b100 && !ctrlR[2]
    |-> timerPin == (ctrlR[3] ^ !ctrlR[4]))
    else $error("forced pwm level wrong");
endmodule : ste_timer_asserts

bind ste_timer ste_timer_asserts u_chk (.clock, .srst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .timerPin, .timerPinOe);

// *** tb/tb.sv ***
// self-checking bench for the timer engine
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic timerPin;
  logic timerPinOe;
  logic [31:0] rd;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  ste_timer u_dut (.clock, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .timerPin, .timerPinOe);

  always #5 clock = ~clock;

  // a hang ends the run as a failure
  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  // one access; request held until waitrequest is seen low
  // no count of its own: only the bench ceiling ends a wait
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wreg

  task automatic rchk(input string nm, input logic [4:0] a,
      input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(nm, e, rd & m);
  endtask : rchk

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  task automatic t_regs;
    rchk("ctrl", 5'h00, 32'hFFFFFFFF, 32'h0);
    wreg(5'h04, 32'hABCD);
    bus(1'b1, 5'h04, 32'h1200, 4'h2);
    rchk("cmpa lanes", 5'h04, 32'hFFFFFFFF, 32'h12CD);
    wreg(5'h14, 32'hFFFFFFFF);
    rchk("unmapped", 5'h14, 32'hFFFFFFFF, 32'h0);
    wreg(5'h0C, 32'h1234);
    rchk("count ro", 5'h0C, 32'hFFFFFFFF, 32'h0);
    $display("test regs done");
  endtask : t_regs

  // toggle on a at 64, p clears every 256
  task automatic t_compare;
    wreg(5'h04, 32'h40);
    wreg(5'h08, 32'h1);
    wreg(5'h00, 32'h138);
    idle(98);
    rchk("a flag pin", 5'h10, 32'h7, 32'h1);
    idle(187);
    rchk("both flags", 5'h10, 32'h7, 32'h3);
    rchk("p clear", 5'h0C, 32'hFFFF, 32'h23);
    $display("test compare done");
  endtask : t_compare

  task automatic t_clear_a;
    wreg(5'h00, 32'h0);
    bus(1'b1, 5'h10, 32'h3, 4'h1);
    wreg(5'h04, 32'h200);
    wreg(5'h00, 32'h101);
    idle(600);
    rchk("a only", 5'h10, 32'h7, 32'h1);
    rchk("a clear", 5'h0C, 32'hFFFF, 32'h5B);
    $display("test clear select done");
  endtask : t_clear_a

  task automatic t_timer;
    wreg(5'h00, 32'h0);
    bus(1'b1, 5'h10, 32'h3, 4'h1);
    wreg(5'h04, 32'h10);
    wreg(5'h08, 32'h0);
    wreg(5'h00, 32'h1F0);
    idle(40);
    chk("released", 32'h0, 32'(timerPinOe));
    rchk("timer flags", 5'h10, 32'h3, 32'h1);
    $display("test timer done");
  endtask : t_timer

  // compare-mode drive low and high, then the undefined mode
  task automatic t_levels;
    wreg(5'h04, 32'h8);
    wreg(5'h00, 32'h0);
    wreg(5'h00, 32'h118);
    idle(20);
    rchk("drive low", 5'h10, 32'h4, 32'h0);
    wreg(5'h00, 32'h0);
    wreg(5'h00, 32'h120);
    idle(20);
    rchk("drive high", 5'h10, 32'h4, 32'h4);
    wreg(5'h00, 32'h0);
    wreg(5'h00, 32'h150);
    idle(4);
    chk("undef released", 32'h0, 32'(timerPinOe));
    $display("test levels done");
  endtask : t_levels

  // count high pin cycles over one whole period
  task automatic pwm_case(input logic [8:0] c, input logic [15:0] a,
      input logic [7:0] p, input int w, input int h, input logic [1:0] f);
    int n;
    n = 0;
    wreg(5'h00, 32'h0);
    bus(1'b1, 5'h10, 32'h3, 4'h1);
    wreg(5'h04, {16'h0, a});
    wreg(5'h08, {24'h0, p});
    wreg(5'h00, {23'h0, c});
    idle(20);
    repeat (w) begin
      @(posedge clock);
      n += (timerPin === 1'b1);
    end
    chk("high count", h, n);
    rchk("pwm flags", 5'h10, 32'h3, {30'h0, f});
  endtask : pwm_case

  task automatic t_pwm;
    pwm_case(9'h1A9, 16'h40, 8'h1, 256, 64, 2'h3);
    pwm_case(9'h1AC, 16'h40, 8'h1, 256, 192, 2'h3);
    pwm_case(9'h1A0, 16'h40, 8'h1, 256, 192, 2'h3);
    pwm_case(9'h1A8, 16'h200, 8'h1, 256, 256, 2'h2);
    pwm_case(9'h1AA, 16'h200, 8'h1, 512, 256, 2'h3);
    pwm_case(9'h198, 16'h40, 8'h1, 256, 256, 2'h3);
    pwm_case(9'h188, 16'h40, 8'h1, 256, 0, 2'h3);
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_pulse;
    wreg(5'h00, 32'h0);
    bus(1'b1, 5'h10, 32'h3, 4'h1);
    wreg(5'h04, 32'h30);
    wreg(5'h00, 32'h1B8);
    idle(10);
    chk("lead", 32'h1, 32'(timerPin));
    idle(60);
    chk("tail", 32'h0, 32'(timerPin));
    rchk("run bit", 5'h00, 32'h100, 32'h0);
    rchk("pulse flag", 5'h10, 32'h3, 32'h1);
    rchk("stopped", 5'h0C, 32'hFFFF, 32'h30);
    idle(20);
    rchk("held", 5'h0C, 32'hFFFF, 32'h30);
    wreg(5'h00, 32'h1B8);
    idle(10);
    rchk("restart", 5'h0C, 32'hFFFF, 32'hA);
    wreg(5'h00, 32'hB8);
    idle(3);
    chk("soft end", 32'h0, 32'(timerPin));
    $display("test pulse done");
  endtask : t_pulse

  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    idle(2);
    t_regs();
    t_compare();
    t_clear_a();
    t_timer();
    t_levels();
    t_pwm();
    t_pulse();
    complete_run();
  end
endmodule : tb
